// file: design/sfrc_params.svh
`ifndef SFRC_PARAMS_SVH
`define SFRC_PARAMS_SVH

// Timebase
`define SFRC_CLK_MHZ        50

// Printed times, in their own units
`define SFRC_T_LATCH_US     210
`define SFRC_T_BROWN_US     270
`define SFRC_T_RISE_US      450
`define SFRC_T_OVL_MS       40

// Cycle counts derived from the printed times (all exact multiples)
`define SFRC_LATCH_CYC      (`SFRC_T_LATCH_US * `SFRC_CLK_MHZ)
`define SFRC_BROWN_CYC      (`SFRC_T_BROWN_US * `SFRC_CLK_MHZ)
`define SFRC_RISE_CYC       (`SFRC_T_RISE_US * `SFRC_CLK_MHZ)
`define SFRC_OVL_CYC        (`SFRC_T_OVL_MS * 1000 * `SFRC_CLK_MHZ)

// Dwell counter width, wide enough for the longest count
`define SFRC_CNT_W          21

// Reset values of the state flags
`define SFRC_BROWN_RST      1'b1
`define SFRC_LATCH_RST      1'b0
`define SFRC_PARITY_RST     1'b0

`endif

// file: design/sfrc_pkg.sv
package sfrc_pkg;

  // Auto restart behaviour; 2'b11 is an illegal code
  typedef enum logic [1:0] {
    AR_NONE = 2'b00,
    AR_ODD  = 2'b01,
    AR_NOSW = 2'b10
  } sfrc_ar_e;

  // Digitised comparator levels from the analog front end
  typedef struct packed {
    logic vccOver;      // Supply above over-voltage trip
    logic tempHot;      // Junction above thermal trip
    logic tempCool;     // Junction dropped by the hysteresis below the trip
    logic lineLatchLow; // Line sense below latch level
    logic lineBrownLow; // Line sense below brownout level
    logic lineRecover;  // Line sense above brownout exit level
    logic fbOver;       // Feedback-burst pin above over-range level
    logic uvloOn;       // Supply lockout released (hysteretic on/off)
    logic refGood;      // Supply above reference-good level
  } sfrc_comp_s;

endpackage : sfrc_pkg

// file: design/sfrc_control.sv
`timescale 1ns/100ps
`default_nettype none
`include "sfrc_params.svh"

// Continuous-condition timer: done once run has held for LIMIT enabled cycles
module sfrc_dwell
  import sfrc_pkg::*;
#(
  parameter int unsigned W     = `SFRC_CNT_W,
  parameter logic [W-1:0] LIMIT = W'(`SFRC_LATCH_CYC)
)
(
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         clkEn,
  input  wire logic         run,
  output logic              done
);

  logic [W-1:0] cnt_r;

  // Any drop of run restarts the window, so short excursions never finish
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_r <= '0;
    else if (clkEn)
    begin
      if (!run)
        cnt_r <= '0;
      else if (cnt_r != LIMIT)
        cnt_r <= cnt_r + W'(1);
    end
  end

  assign done = run && (cnt_r == LIMIT);

endmodule : sfrc_dwell

// Summary of operation
// (R1) Odd-skip: odd restart cycles have no fault detection and no switching.
// (R2) Odd-skip: even cycles detect and switch; return normal only on clean even cycle.
// (R3) Non-switching restart: never switch; detect at even cycles, release when fault gone.
// (R4) Over-voltage/overload odd-skip; undervoltage normal; over-temperature non-switch; external latch.
// (R5) Supply over-voltage comparator high enters odd-skip auto restart.
// (R6) Over-temperature enters non-switch restart; leave only after hysteresis cooling.
// (R7) Line sense below latch level for full blanking time latches; shorter does not.
// (R8) While latched the gate stays off.
// (R9) Lockout off stops switching and enables start-up cell; lockout on restarts.
// (R10) Shorted optocoupler handled purely through the supply undervoltage path.
// (R11) Feedback over-range held for the overload blanking time enters odd-skip.
// (R12) Line sense below brownout level for its blanking time enters brownout.
// (R13) Brownout clears when line sense rises above exit level.
// (R14) Brownout set at power-up, held until reference good and lockout on.
// (R15) Brownout stops switching; line sense is re-checked every restart cycle.
// (R16) Reference-good loss (supply below 8V) clears the latch.
// (R17) Slow line rise, latch level to brownout level, clears the latch.
// (R18) Parity starts odd on restart entry, toggles per lockout-on, cleared on release.
module sfrc_control
  import sfrc_pkg::*;
#(
  parameter int unsigned LATCH_CYC = `SFRC_LATCH_CYC,
  parameter int unsigned BROWN_CYC = `SFRC_BROWN_CYC,
  parameter int unsigned RISE_CYC  = `SFRC_RISE_CYC,
  parameter int unsigned OVL_CYC   = `SFRC_OVL_CYC
)
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       clkEn,
  input  wire sfrc_comp_s compIn,
  output logic            gateEn,
  output logic            startupCellEn,
  output logic            faultDetectEn,
  output logic            latched,
  output logic            brownout,
  output sfrc_ar_e        restartMode,
  output logic            oddCycle
);

  sfrc_comp_s compMeta_r;
  sfrc_comp_s cmp_r;
  logic       uvloPrev_r;
  logic       brownout_r;
  logic       latched_r;
  logic       pullSeen_r;
  logic       parity_r;
  sfrc_ar_e   arMode_r;
  logic       latchDone;
  logic       brownDone;
  logic       riseDone;
  logic       ovlDone;
  logic       uvloRise;
  logic       evenOn;

  // Comparator levels are asynchronous to the timebase: two-stage synchroniser
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      compMeta_r <= '0;
      cmp_r      <= '0;
    end
    else if (clkEn)
    begin
      compMeta_r <= compIn;
      cmp_r      <= compMeta_r;
    end
  end

  // Lockout edge, used to count restart cycles
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      uvloPrev_r <= 1'b0;
    else if (clkEn)
      uvloPrev_r <= cmp_r.uvloOn;
  end

  assign uvloRise = cmp_r.uvloOn && !uvloPrev_r;
  assign evenOn   = cmp_r.uvloOn && !parity_r;

  // External latch blanking; shorter pull-downs restart the window
  sfrc_dwell #(.W(`SFRC_CNT_W), .LIMIT(`SFRC_CNT_W'(LATCH_CYC))) u_latch_dwell (
    .clk   (clk),
    .rstn  (rstn),
    .clkEn (clkEn),
    .run   (cmp_r.refGood && cmp_r.lineLatchLow), // [R7]
    .done  (latchDone)
  );

  // Brownout blanking; only runs once the reference is good
  sfrc_dwell #(.W(`SFRC_CNT_W), .LIMIT(`SFRC_CNT_W'(BROWN_CYC))) u_brown_dwell (
    .clk   (clk),
    .rstn  (rstn),
    .clkEn (clkEn),
    .run   (cmp_r.refGood && cmp_r.lineBrownLow), // [R12] [R14]
    .done  (brownDone)
  );

  // Slow rise between the two line levels after a pull-down
  sfrc_dwell #(.W(`SFRC_CNT_W), .LIMIT(`SFRC_CNT_W'(RISE_CYC))) u_rise_dwell (
    .clk   (clk),
    .rstn  (rstn),
    .clkEn (clkEn),
    .run   (pullSeen_r && !cmp_r.lineLatchLow && cmp_r.lineBrownLow), // [R17]
    .done  (riseDone)
  );

  // Overload / open loop blanking, counted only while faults are being looked at
  sfrc_dwell #(.W(`SFRC_CNT_W), .LIMIT(`SFRC_CNT_W'(OVL_CYC))) u_ovl_dwell (
    .clk   (clk),
    .rstn  (rstn),
    .clkEn (clkEn),
    .run   (faultDetectEn && (arMode_r == AR_NONE) && cmp_r.fbOver), // [R11]
    .done  (ovlDone)
  );

  // Pull-down seen: armed below latch level, dropped once the pin clears 1V
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pullSeen_r <= 1'b0;
    else if (clkEn)
    begin
      if (cmp_r.lineLatchLow)
        pullSeen_r <= 1'b1;
      else if (!cmp_r.lineBrownLow || riseDone)
        pullSeen_r <= 1'b0;
    end
  end

  // Latch; reference-loss clear wins over set, and set and slow-rise clear cannot coincide
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      latched_r <= `SFRC_LATCH_RST;
    else if (clkEn)
    begin
      if (!cmp_r.refGood)
        latched_r <= 1'b0;                     // [R16]
      else if (latchDone)
        latched_r <= 1'b1;                     // [R4] [R7]
      else if (riseDone)
        latched_r <= 1'b0;                     // [R17]
    end
  end

  // Brownout flag; held set through lockout so every restart cycle re-checks the line
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      brownout_r <= `SFRC_BROWN_RST;           // [R14]
    else if (clkEn)
    begin
      if (!cmp_r.refGood || !cmp_r.uvloOn)
        brownout_r <= 1'b1;                    // [R14] [R15]
      else if (brownDone)
        brownout_r <= 1'b1;                    // [R12]
      else if (cmp_r.lineRecover)
        brownout_r <= 1'b0;                    // [R13]
    end
  end

  // Restart mode and cycle parity; thermal outranks over-voltage and overload
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      arMode_r <= AR_NONE;
      parity_r <= `SFRC_PARITY_RST;
    end
    else if (clkEn)
    begin
      if (!cmp_r.refGood)
      begin
        arMode_r <= AR_NONE;
        parity_r <= 1'b0;
      end
      else
      begin
        unique case (arMode_r)
          AR_NONE:
          begin
            if (faultDetectEn && cmp_r.tempHot)
            begin
              arMode_r <= AR_NOSW;             // [R4] [R6]
              parity_r <= 1'b1;                // [R18]
            end
            else if (faultDetectEn && (cmp_r.vccOver || ovlDone))
            begin
              arMode_r <= AR_ODD;              // [R4] [R5] [R11]
              parity_r <= 1'b1;                // [R18]
            end
          end
          AR_ODD:
          begin
            if (uvloRise)
              parity_r <= !parity_r;           // [R18]
            else if (evenOn && cmp_r.tempHot)
            begin
              arMode_r <= AR_NOSW;
              parity_r <= 1'b1;
            end
            else if (evenOn && !cmp_r.vccOver && !cmp_r.fbOver)
            begin
              arMode_r <= AR_NONE;             // [R2]
              parity_r <= 1'b0;                // [R18]
            end
          end
          AR_NOSW:
          begin
            if (uvloRise)
              parity_r <= !parity_r;           // [R18]
            else if (evenOn && cmp_r.tempCool)
            begin
              arMode_r <= AR_NONE;             // [R3] [R6]
              parity_r <= 1'b0;                // [R18]
            end
          end
          default:
          begin
            arMode_r <= AR_NONE;
            parity_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // Detection is blind in odd cycles and whenever the supply is locked out
  assign faultDetectEn = cmp_r.uvloOn && !latched_r && !brownout_r
                         && ((arMode_r == AR_NONE) || !parity_r);          // [R1] [R2] [R3]

  // Gate drive: normal run, or soft start in an even odd-skip cycle
  assign gateEn = cmp_r.uvloOn && !latched_r && !brownout_r                // [R8] [R9] [R15]
                  && ((arMode_r == AR_NONE) || ((arMode_r == AR_ODD) && !parity_r)); // [R1] [R3]

  // Start-up cell charges the supply whenever lockout is off; a shorted opto lands here
  assign startupCellEn = !cmp_r.uvloOn;                                    // [R9] [R10]
  assign latched       = latched_r;
  assign brownout      = brownout_r;
  assign restartMode   = arMode_r;
  assign oddCycle      = parity_r;

  sequence s_even_clean;
    (arMode_r == AR_ODD) && evenOn && !uvloRise && !cmp_r.tempHot && !cmp_r.vccOver && !cmp_r.fbOver;
  endsequence

  sequence s_entry;
    (arMode_r == AR_NONE) ##1 (arMode_r != AR_NONE);
  endsequence

  a_odd_cycle_quiet: assert property (@(posedge clk) disable iff (!rstn) // [R1]
    ((arMode_r == AR_ODD) && parity_r) |-> (!gateEn && !faultDetectEn))
    else $error("switching or detection in odd cycle");

  a_even_release: assert property (@(posedge clk) disable iff (!rstn) // [R2]
    (clkEn && cmp_r.refGood) ##0 s_even_clean |=> (arMode_r == AR_NONE) && !parity_r)
    else $error("clean even cycle did not release");

  a_nosw_no_gate: assert property (@(posedge clk) disable iff (!rstn) // [R3]
    (arMode_r == AR_NOSW) |-> !gateEn)
    else $error("gate active in non-switch restart");

  a_ovp_entry: assert property (@(posedge clk) disable iff (!rstn) // [R5]
    (clkEn && cmp_r.refGood && faultDetectEn && (arMode_r == AR_NONE) && cmp_r.vccOver && !cmp_r.tempHot)
    |=> (arMode_r == AR_ODD) && parity_r)
    else $error("over-voltage did not enter odd-skip");

  a_otp_entry: assert property (@(posedge clk) disable iff (!rstn) // [R6]
    (clkEn && cmp_r.refGood && faultDetectEn && (arMode_r == AR_NONE) && cmp_r.tempHot)
    |=> (arMode_r == AR_NOSW))
    else $error("over-temperature did not enter non-switch");

  a_latch_gate_off: assert property (@(posedge clk) disable iff (!rstn) // [R8]
    latched_r |-> (!gateEn && !faultDetectEn))
    else $error("gate active while latched");

  a_supply_undervoltage_lockout_off_cell: assert property (@(posedge clk) disable iff (!rstn) // [R9]
    !cmp_r.uvloOn |-> (startupCellEn && !gateEn))
    else $error("lockout off but start-up cell idle");

  a_brown_gate_off: assert property (@(posedge clk) disable iff (!rstn) // [R15]
    brownout_r |-> !gateEn)
    else $error("gate active in brownout");

  a_refgood_clear: assert property (@(posedge clk) disable iff (!rstn) // [R16]
    (clkEn && !cmp_r.refGood) |=> (!latched_r && brownout_r))
    else $error("reference loss did not clear latch");

  a_latch_needs_hold: assert property (@(posedge clk) disable iff (!rstn) // [R7]
    (clkEn && !latched_r && !cmp_r.lineLatchLow) |=> !latched_r)
    else $error("latch set without full blanking");

  a_parity_entry: assert property (@(posedge clk) disable iff (!rstn) // [R18]
    s_entry |-> parity_r)
    else $error("restart entry not at odd parity");

  a_recover_clear: assert property (@(posedge clk) disable iff (!rstn) // [R13]
    (clkEn && brownout_r && cmp_r.refGood && cmp_r.uvloOn && !brownDone && cmp_r.lineRecover) |=> !brownout_r)
    else $error("brownout not cleared on line recovery");

endmodule : sfrc_control

`default_nettype wire

// file: sim/sfrc_control_tb.sv
`timescale 1ns/100ps
`default_nettype none

// Drives comparator levels at rising edges and judges settled outputs at falling edges
module sfrc_control_tb
  import sfrc_pkg::*;
;
  // Short dwell counts keep the run brief; the blanking waits below are derived from them
  localparam int unsigned LATCH = 20;
  localparam int unsigned BROWN = 30;
  localparam int unsigned RISE  = 50;
  localparam int unsigned OVL   = 100;

  logic       clk   = 1'b0;
  logic       rstn  = 1'b0;
  logic       clkEn = 1'b1;
  sfrc_comp_s c     = '0;
  logic       gateEn;
  logic       startupCellEn;
  logic       faultDetectEn;
  logic       latched;
  logic       brownout;
  sfrc_ar_e   restartMode;
  logic       oddCycle;
  int         miscompares = 0;
  int         checksDone  = 0;

  sfrc_control #(.LATCH_CYC(LATCH), .BROWN_CYC(BROWN), .RISE_CYC(RISE), .OVL_CYC(OVL)) i_dut (
    .clk          (clk),
    .rstn         (rstn),
    .clkEn        (clkEn),
    .compIn       (c),
    .gateEn       (gateEn),
    .startupCellEn(startupCellEn),
    .faultDetectEn(faultDetectEn),
    .latched      (latched),
    .brownout     (brownout),
    .restartMode  (restartMode),
    .oddCycle     (oddCycle)
  );

  // 50 MHz timebase
  always #10 clk = ~clk;

  task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Ends at a falling edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc

  // Line-sense comparators; recover is the inverse of the brownout level
  task automatic pull(input logic lo, input logic bo);
    @(posedge clk);
    c.lineLatchLow <= lo;
    c.lineBrownLow <= bo;
    c.lineRecover  <= !bo;
  endtask : pull

  // One lockout off/on cycle; margins cover the two-flop synchroniser
  task automatic supply_undervoltage_lockout_cycle();
    @(posedge clk) c.uvloOn <= 1'b0;
    cyc(6);
    chk("startupCellEn", 4'(startupCellEn), 4'h1);
    chk("gateEn lockout", 4'(gateEn), 4'h0);
    @(posedge clk) c.uvloOn <= 1'b1;
    cyc(6);
  endtask : supply_undervoltage_lockout_cycle

  task automatic t_reset();
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk("brownout rst", 4'(brownout), 4'h1);
    chk("latched rst", 4'(latched), 4'h0);
    chk("gateEn rst", 4'(gateEn), 4'h0);
    chk("mode rst", 4'(restartMode), 4'(AR_NONE));
    chk("odd rst", 4'(oddCycle), 4'h0);
    @(posedge clk);
    rstn      <= 1'b1;
    c.refGood <= 1'b1;
    cyc(8);
    chk("brownout pre-on", 4'(brownout), 4'h1);
    @(posedge clk);
    c.uvloOn      <= 1'b1;
    c.lineRecover <= 1'b1;
    cyc(6);
    chk("brownout on", 4'(brownout), 4'h0);
    chk("gateEn on", 4'(gateEn), 4'h1);
    chk("detect on", 4'(faultDetectEn), 4'h1);
    chk("startup off", 4'(startupCellEn), 4'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_latch();
    // Short excursion must not latch
    pull(1'b1, 1'b1);
    cyc(LATCH - 4);
    pull(1'b0, 1'b0);
    cyc(6);
    chk("latched short", 4'(latched), 4'h0);
    pull(1'b1, 1'b1);
    cyc(LATCH + 6);
    chk("latched long", 4'(latched), 4'h1);
    chk("gateEn latched", 4'(gateEn), 4'h0);
    // Fast rise keeps the latch
    pull(1'b0, 1'b1);
    cyc(RISE - 10);
    pull(1'b0, 1'b0);
    cyc(6);
    chk("latched fast", 4'(latched), 4'h1);
    chk("gateEn fast", 4'(gateEn), 4'h0);
    // Slow rise clears it
    pull(1'b1, 1'b1);
    cyc(4);
    pull(1'b0, 1'b1);
    cyc(RISE + 6);
    chk("latched slow", 4'(latched), 4'h0);
    pull(1'b0, 1'b0);
    cyc(6);
    // Reference loss clears a latch that the line alone would keep
    pull(1'b1, 1'b1);
    cyc(LATCH + 6);
    chk("latched again", 4'(latched), 4'h1);
    pull(1'b0, 1'b0);
    c.refGood <= 1'b0;
    cyc(5);
    chk("latched refgood", 4'(latched), 4'h0);
    @(posedge clk) c.refGood <= 1'b1;
    cyc(8);
    chk("gateEn unlatched", 4'(gateEn), 4'h1);
    $display("test latch done");
  endtask : t_latch

  task automatic t_odd();
    @(posedge clk) c.vccOver <= 1'b1;
    cyc(5);
    chk("mode ovp", 4'(restartMode), 4'(AR_ODD));
    chk("odd entry", 4'(oddCycle), 4'h1);
    chk("gateEn odd", 4'(gateEn), 4'h0);
    chk("detect odd", 4'(faultDetectEn), 4'h0);
    supply_undervoltage_lockout_cycle();
    chk("odd even", 4'(oddCycle), 4'h0);
    chk("mode fault", 4'(restartMode), 4'(AR_ODD));
    chk("gateEn even", 4'(gateEn), 4'h1);
    chk("detect even", 4'(faultDetectEn), 4'h1);
    supply_undervoltage_lockout_cycle();
    chk("odd again", 4'(oddCycle), 4'h1);
    chk("gateEn odd2", 4'(gateEn), 4'h0);
    @(posedge clk) c.vccOver <= 1'b0;
    cyc(5);
    chk("mode odd hold", 4'(restartMode), 4'(AR_ODD));
    supply_undervoltage_lockout_cycle();
    chk("mode release", 4'(restartMode), 4'(AR_NONE));
    chk("odd cleared", 4'(oddCycle), 4'h0);
    supply_undervoltage_lockout_cycle();
    chk("mode supply_undervoltage_lockout", 4'(restartMode), 4'(AR_NONE));
    chk("gateEn supply_undervoltage_lockout", 4'(gateEn), 4'h1);
    $display("test odd-skip done");
  endtask : t_odd

  task automatic t_nosw();
    @(posedge clk) c.tempHot <= 1'b1;
    cyc(5);
    chk("mode hot", 4'(restartMode), 4'(AR_NOSW));
    @(posedge clk) c.tempHot <= 1'b0;
    supply_undervoltage_lockout_cycle();
    chk("mode warm", 4'(restartMode), 4'(AR_NOSW));
    chk("gateEn nosw", 4'(gateEn), 4'h0);
    chk("detect nosw", 4'(faultDetectEn), 4'h1);
    // Cooling seen in an even cycle releases at once, so it is raised in the odd one
    supply_undervoltage_lockout_cycle();
    @(posedge clk) c.tempCool <= 1'b1;
    cyc(5);
    chk("mode odd cool", 4'(restartMode), 4'(AR_NOSW));
    chk("gateEn odd cool", 4'(gateEn), 4'h0);
    supply_undervoltage_lockout_cycle();
    chk("mode cool", 4'(restartMode), 4'(AR_NONE));
    @(posedge clk) c.tempCool <= 1'b0;
    $display("test non-switch done");
  endtask : t_nosw

  task automatic t_ovl();
    @(posedge clk) c.fbOver <= 1'b1;
    cyc(OVL - 10);
    @(posedge clk) c.fbOver <= 1'b0;
    cyc(5);
    chk("mode ovl short", 4'(restartMode), 4'(AR_NONE));
    @(posedge clk) c.fbOver <= 1'b1;
    cyc(OVL + 8);
    chk("mode ovl", 4'(restartMode), 4'(AR_ODD));
    @(posedge clk) c.fbOver <= 1'b0;
    supply_undervoltage_lockout_cycle();
    chk("mode ovl end", 4'(restartMode), 4'(AR_NONE));
    $display("test overload done");
  endtask : t_ovl

  task automatic t_brown();
    pull(1'b0, 1'b1);
    cyc(BROWN - 8);
    pull(1'b0, 1'b0);
    cyc(5);
    chk("brownout short", 4'(brownout), 4'h0);
    pull(1'b0, 1'b1);
    cyc(BROWN + 8);
    chk("brownout long", 4'(brownout), 4'h1);
    chk("gateEn brown", 4'(gateEn), 4'h0);
    supply_undervoltage_lockout_cycle();
    chk("brownout recheck", 4'(brownout), 4'h1);
    pull(1'b0, 1'b0);
    cyc(5);
    chk("brownout exit", 4'(brownout), 4'h0);
    chk("gateEn exit", 4'(gateEn), 4'h1);
    $display("test brownout done");
  endtask : t_brown

  // Clock enable low freezes the synchroniser, so a fault waits until it returns
  task automatic t_freeze();
    @(posedge clk);
    clkEn     <= 1'b0;
    c.vccOver <= 1'b1;
    cyc(10);
    chk("mode frozen", 4'(restartMode), 4'(AR_NONE));
    chk("gateEn frozen", 4'(gateEn), 4'h1);
    @(posedge clk) clkEn <= 1'b1;
    cyc(5);
    chk("mode thawed", 4'(restartMode), 4'(AR_ODD));
    // Over-temperature found at an even cycle moves odd-skip to non-switch
    @(posedge clk);
    c.vccOver <= 1'b0;
    c.tempHot <= 1'b1;
    supply_undervoltage_lockout_cycle();
    chk("mode odd to hot", 4'(restartMode), 4'(AR_NOSW));
    chk("odd hot", 4'(oddCycle), 4'h1);
    @(posedge clk);
    c.tempHot  <= 1'b0;
    c.tempCool <= 1'b1;
    supply_undervoltage_lockout_cycle();
    chk("mode hot cleared", 4'(restartMode), 4'(AR_NONE));
    @(posedge clk) c.tempCool <= 1'b0;
    $display("test freeze done");
  endtask : t_freeze

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  initial
  begin
    t_reset();
    t_latch();
    t_odd();
    t_nosw();
    t_ovl();
    t_brown();
    t_freeze();
    end_sim();
  end

  // The sequence takes roughly 710 cycles; allow ample margin
  initial
  begin
    #400000;
    miscompares++;
    end_sim();
  end

endmodule : sfrc_control_tb

`default_nettype wire
